// [rtl/aqd_top.sv]
// Purpose: Acquisition control: qualification, depth, post-trigger delay
// Assumes: Pod inputs asynchronous; external clock sampled as a level
// Notes: One frame per recording clock; memory is outside this block
`timescale 1ns/100ps
module aqd_top
  import aqd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] pod_data,       // Demultiplexed frame from pod
  input wire logic pod_glitch,            // Glitch flag from fast pod
  input wire logic ext_clk,               // Target clock, sampled
  input wire logic clk_qual,              // Clock qualifier pin
  input wire logic int_tick,              // Internal time-base tick, same domain
  input wire logic trig_hit,              // Trigger recognised, same domain
  output aqd_mem_s mem_wr,                // Acquisition memory write
  output logic glitch_en,                 // Command to fast pod
  output logic recording,                 // Armed or delaying
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0][31:0] dsync;   // Pod data synchroniser
    logic [1:0] gsync;         // Glitch synchroniser
    logic [2:0] esync;         // Ext clock sync plus edge history
    logic [1:0] qsync;         // Qualifier synchroniser
    logic [31:0] ctrl;         // Control register
    logic [15:0] delay;        // Programmed delay
    logic [31:0] qword;        // Qualification word
    logic [31:0] qmask;        // Qualification care mask
    logic [31:0] cursor;       // [31:16] reference, [15:0] main
    aqd_phase_e phase;         // Recording phase
    logic qgate;               // State-mode recording gate
    logic [12:0] waddr;        // Write pointer
    logic [12:0] stored;       // Samples stored, saturating at depth
    logic [15:0] dcount;       // Post-trigger count
    logic [31:0] ticks;        // Clock intervals since start
    logic [31:0] trig_tick;    // Interval count at trigger
    aqd_mem_s mem;             // Registered memory write
    logic awhave;              // Write address held
    logic whave;               // Write data held
    logic [7:0] awaddr;        // Held write address
    logic [31:0] wdata;        // Held write data
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aqd_state_s;

  aqd_state_s st_reg;
  aqd_state_s st_next;

  // Combinational helpers
  aqd_width_e width;
  logic ext_mode;
  logic rec_clk;
  logic sample_ok;
  logic match;
  logic [12:0] depth;
  logic [15:0] main_c;
  logic [15:0] ref_c;

  // ==========================================================
  // Datapath and decode
  always_comb begin
    width = aqd_width_e'(st_reg.ctrl[AQD_C_WLO +: 2]);
    ext_mode = st_reg.ctrl[AQD_C_EXTCLK];
    // Recording clock: external rising edge or internal tick
    if (ext_mode) begin
      // Qualifier gates only the external clock
      rec_clk = st_reg.esync[1] & ~st_reg.esync[2]
        & (st_reg.qsync[1] == st_reg.ctrl[AQD_C_CQPOL]);
    end else begin
      rec_clk = int_tick;
    end
    match = ((st_reg.dsync[1] ^ st_reg.qword) & st_reg.qmask) == 32'h0000_0000;
    // Depth set by width
    case (width)
      AQD_W4: depth = AQD_DEPTH_W4;
      AQD_W8: depth = AQD_DEPTH_W8;
      AQD_W16: depth = AQD_DEPTH_W16;
      default: depth = AQD_DEPTH_W32;
    endcase
    // Qualification only when 32 wide
    if (!st_reg.ctrl[AQD_C_QEN] || width != AQD_W32) begin
      sample_ok = 1'b1;
    end else if (st_reg.ctrl[AQD_C_QCOMB]) begin
      sample_ok = match ^ st_reg.ctrl[AQD_C_QINV];
    end else begin
      sample_ok = st_reg.qgate ^ match;
    end
    main_c = st_reg.cursor[15:0];
    ref_c = st_reg.cursor[31:16];
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.dsync = {st_reg.dsync[0], pod_data};
    st_next.gsync = {st_reg.gsync[0], pod_glitch};
    st_next.esync = {st_reg.esync[1:0], ext_clk};
    st_next.qsync = {st_reg.qsync[0], clk_qual};
    st_next.mem.we = 1'b0;
    st_next.ctrl[AQD_C_START] = 1'b0;
    st_next.ctrl[AQD_C_STOP] = 1'b0;

    // Interval counter: ext periods or internal units
    if (st_reg.phase != AQD_IDLE && st_reg.phase != AQD_DONE && rec_clk) begin
      st_next.ticks = st_reg.ticks + 32'h0000_0001;
    end

    // Recording sequence
    case (st_reg.phase)
      AQD_IDLE: begin
        // Idle until armed
      end
      AQD_ARMED, AQD_DELAY: begin
        // No store in the cycle the delay runs out, so stores after the trigger stop at the delay count
        if (rec_clk && !(st_reg.phase == AQD_DELAY && st_reg.dcount >= st_reg.delay)) begin
          // State mode: match flips the gate
          if (match) begin
            st_next.qgate = ~st_reg.qgate;
          end
          if (sample_ok) begin
            st_next.mem.we = 1'b1;
            st_next.mem.addr = st_reg.waddr;
            st_next.mem.data = st_reg.dsync[1];
            // Glitch flag only on 4-channel path when enabled
            st_next.mem.glitch = st_reg.gsync[1] & st_reg.ctrl[AQD_C_GLITCH]
              & (width == AQD_W4);
            // Circular write within the width's depth
            st_next.waddr = (st_reg.waddr == depth - 13'h0001) ? 13'h0000
              : st_reg.waddr + 13'h0001;
            if (st_reg.stored != depth) begin
              st_next.stored = st_reg.stored + 13'h0001;
            end
            if (st_reg.phase == AQD_DELAY) begin
              st_next.dcount = st_reg.dcount + 16'h0001;
            end
          end
        end
        if (st_reg.phase == AQD_ARMED && trig_hit) begin
          st_next.trig_tick = st_reg.ticks;
          st_next.dcount = 16'h0000;
          st_next.phase = (st_reg.delay == 16'h0000) ? AQD_DONE : AQD_DELAY;
        end
        // Stop once delay count reached
        if (st_reg.phase == AQD_DELAY && st_reg.dcount >= st_reg.delay) begin
          st_next.phase = AQD_DONE;
        end
      end
      AQD_DONE: begin
        // Hold until rearmed
      end
      default: st_next.phase = AQD_IDLE;
    endcase

    // ========================================================
    // AXI4-Lite write channel
    if (s_axi_awvalid && !st_reg.awhave) begin
      st_next.awhave = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.whave) begin
      st_next.whave = 1'b1;
      st_next.wdata = s_axi_wdata;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.awhave && st_reg.whave && !st_reg.bvalid) begin
      st_next.awhave = 1'b0;
      st_next.whave = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'h0;
      // Address decode, full-word writes
      if (st_reg.awaddr == AQD_CTRL_OFS) begin
        st_next.ctrl = st_reg.wdata;
        if (st_reg.wdata[AQD_C_START]) begin
          st_next.phase = AQD_ARMED;
          st_next.waddr = 13'h0000;
          st_next.stored = 13'h0000;
          st_next.ticks = 32'h0000_0000;
          st_next.qgate = 1'b0;
        end
        if (st_reg.wdata[AQD_C_STOP]) begin
          st_next.phase = AQD_DONE;
        end
      end else if (st_reg.awaddr == AQD_DELAY_OFS) begin
        // Clamp to the supported range
        st_next.delay = (st_reg.wdata[15:0] > AQD_DELAY_MAX || |st_reg.wdata[31:16])
          ? AQD_DELAY_MAX : st_reg.wdata[15:0];
      end else if (st_reg.awaddr == AQD_QWORD_OFS) begin
        st_next.qword = st_reg.wdata;
      end else if (st_reg.awaddr == AQD_QMASK_OFS) begin
        st_next.qmask = st_reg.wdata;
      end else if (st_reg.awaddr == AQD_CURSOR_OFS) begin
        st_next.cursor = st_reg.wdata;
      end else if (st_reg.awaddr == AQD_STATUS_OFS || st_reg.awaddr == AQD_COUNT_OFS
                   || st_reg.awaddr == AQD_MEAS_OFS || st_reg.awaddr == AQD_TICKS_OFS) begin
        st_next.bresp = 2'h0;  // Read-only, write ignored
      end else begin
        st_next.bresp = 2'h3;  // Unmapped
      end
    end

    // AXI4-Lite read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'h0;
      if (s_axi_araddr == AQD_CTRL_OFS) begin
        st_next.rdata = st_reg.ctrl;
      end else if (s_axi_araddr == AQD_DELAY_OFS) begin
        st_next.rdata = {16'h0000, st_reg.delay};
      end else if (s_axi_araddr == AQD_QWORD_OFS) begin
        st_next.rdata = st_reg.qword;
      end else if (s_axi_araddr == AQD_QMASK_OFS) begin
        st_next.rdata = st_reg.qmask;
      end else if (s_axi_araddr == AQD_STATUS_OFS) begin
        st_next.rdata = {8'h00, st_reg.dcount, st_reg.qgate, 3'h0, st_reg.phase};
      end else if (s_axi_araddr == AQD_COUNT_OFS) begin
        st_next.rdata = {3'h0, st_reg.waddr, 3'h0, st_reg.stored};
      end else if (s_axi_araddr == AQD_CURSOR_OFS) begin
        st_next.rdata = st_reg.cursor;
      end else if (s_axi_araddr == AQD_MEAS_OFS) begin
        // Reference-to-main if set, else trigger-to-main
        st_next.rdata = st_reg.ctrl[AQD_C_REFEN] ? {16'h0000, main_c - ref_c}
          : {16'h0000, main_c};
      end else if (s_axi_araddr == AQD_TICKS_OFS) begin
        st_next.rdata = st_reg.ticks - st_reg.trig_tick;
      end else begin
        st_next.rdata = 32'h0000_0000;
        st_next.rresp = 2'h3;
      end
    end
  end

  // ==========================================================
  // Register all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= AQD_CTRL_RST;
      st_reg.phase <= AQD_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign mem_wr = st_reg.mem;
  assign glitch_en = st_reg.ctrl[AQD_C_GLITCH] & (width == AQD_W4);
  assign recording = (st_reg.phase == AQD_ARMED) || (st_reg.phase == AQD_DELAY);
  assign s_axi_awready = ~st_reg.awhave;
  assign s_axi_wready = ~st_reg.whave;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

endmodule : aqd_top

// [shared/aqd_pkg.sv]
// Purpose: Shared constants and types for the acquisition qualify/delay block
// Assumes: AXI4-Lite register access, 32-bit data, 250 MHz system clock
// Notes: Register offsets are byte addresses of aligned words
package aqd_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] AQD_CTRL_OFS = 8'h00;    // Control bits
  localparam logic [7:0] AQD_DELAY_OFS = 8'h04;   // Post-trigger delay
  localparam logic [7:0] AQD_QWORD_OFS = 8'h08;   // Qualification word
  localparam logic [7:0] AQD_QMASK_OFS = 8'h0C;   // Qualification care mask
  localparam logic [7:0] AQD_STATUS_OFS = 8'h10;  // Status
  localparam logic [7:0] AQD_COUNT_OFS = 8'h14;   // Samples stored
  localparam logic [7:0] AQD_CURSOR_OFS = 8'h18;  // Main/reference cursors
  localparam logic [7:0] AQD_MEAS_OFS = 8'h1C;    // Measured intervals
  localparam logic [7:0] AQD_TICKS_OFS = 8'h20;   // Clock intervals since trigger

  // ==========================================================
  // Control field positions
  localparam int AQD_C_START = 0;     // Write 1: arm recording (pulse)
  localparam int AQD_C_STOP = 1;      // Write 1: manual stop (pulse)
  localparam int AQD_C_WLO = 2;       // Width code low bit
  localparam int AQD_C_QEN = 4;       // Qualification enable
  localparam int AQD_C_QCOMB = 5;     // 1 combinational, 0 state mode
  localparam int AQD_C_QINV = 6;      // Combinational: store on mismatch
  localparam int AQD_C_EXTCLK = 7;    // Record on external clock
  localparam int AQD_C_GLITCH = 8;    // Glitch capture on fast path
  localparam int AQD_C_REFEN = 9;     // Reference cursor set
  localparam int AQD_C_CQPOL = 10;    // Clock qualifier active level

  // Reset values and limits
  localparam logic [15:0] AQD_DELAY_MAX = 16'hC350;   // 50000 stored samples
  localparam logic [12:0] AQD_DEPTH_W4 = 13'h1F40;    // 8000 samples
  localparam logic [12:0] AQD_DEPTH_W8 = 13'h0FA0;    // 4000 samples
  localparam logic [12:0] AQD_DEPTH_W16 = 13'h07D0;   // 2000 samples
  localparam logic [12:0] AQD_DEPTH_W32 = 13'h03E8;   // 1000 samples
  localparam logic [31:0] AQD_CTRL_RST = 32'h0000_0000;

  // Channel width codes
  typedef enum logic [1:0] {
    AQD_W4 = 2'h0,
    AQD_W8 = 2'h1,
    AQD_W16 = 2'h2,
    AQD_W32 = 2'h3
  } aqd_width_e;

  // Recording phase, one-hot
  typedef enum logic [3:0] {
    AQD_IDLE = 4'h1,
    AQD_ARMED = 4'h2,
    AQD_DELAY = 4'h4,
    AQD_DONE = 4'h8
  } aqd_phase_e;

  // Memory write port
  typedef struct packed {
    logic we;
    logic [12:0] addr;
    logic [31:0] data;
    logic glitch;
  } aqd_mem_s;

endpackage : aqd_pkg

// [verification/aqd_pod_model.sv]
// Purpose: Behavioural input pod facing aqd_top
// Assumes: Pod registers its lines on the system clock
// Notes: Target clock runs only when asked to
`timescale 1ns/100ps
module aqd_pod_model (
  input wire logic clk,
  input wire logic [31:0] word, // Pattern on the probes
  input wire logic ext_run, // Run target clock
  input wire logic qual_lvl, // Qualifier probe level
  input wire logic glitch_en, // Glitch capture command
  output logic [31:0] pod_data,
  output logic pod_glitch,
  output logic ext_clk,
  output logic clk_qual
);
  logic [1:0] div_reg = 2'h0; // Half-period divider
  // ==========================================
  // Registered probe outputs
  initial begin
    pod_data = 32'h0;
    pod_glitch = 1'h0;
    ext_clk = 1'h0;
    clk_qual = 1'h0;
  end
  always @(posedge clk) begin
    pod_data <= word;
    clk_qual <= qual_lvl;
    pod_glitch <= glitch_en & word[0]; // Reports only when commanded
    if (!ext_run) begin
      div_reg <= 2'h0;
      ext_clk <= 1'h0; // Still between bursts
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) ext_clk <= ~ext_clk;
    end
  end
endmodule : aqd_pod_model

// [verification/aqd_props.sv]
// Purpose: Port checker for aqd_top
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by the bind at the foot
`timescale 1ns/100ps
module aqd_props
  import aqd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire aqd_mem_s mem_wr,
  input wire logic recording,
  input wire logic glitch_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Bus handshake steps
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  // ==========================================
  // Register bus
  // Taken at one edge, executed at the next, so bvalid shows two edges on
  bresp_after_both_a: assert property (wr_both |-> ##2 s_axi_bvalid) else $error("bvalid late");
  bresp_holds_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  bresp_clears_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  rdata_follows_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid late");
  rdata_holds_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  // ==========================================
  // Acquisition memory writes
  depth_bound_a: assert property (mem_wr.we |-> mem_wr.addr < AQD_DEPTH_W4)
    else $error("address past depth");
  store_when_rec_a: assert property (mem_wr.we |-> $past(recording))
    else $error("store while stopped");
  // Last stored address, so a skipped slot shows
  logic [12:0] prev_addr;
  always_ff @(posedge clk) begin
    if (mem_wr.we) begin
      prev_addr <= mem_wr.addr;
    end
  end
  addr_steps_a: assert property (mem_wr.we |-> mem_wr.addr == 13'h0000
    || mem_wr.addr == prev_addr + 13'h0001) else $error("address skipped");
  glitch_gate_a: assert property (mem_wr.we && mem_wr.glitch |-> $past(glitch_en))
    else $error("glitch while off");
endmodule : aqd_props

bind aqd_top aqd_props i_props (.*);

// [verification/aqd_top_tb.sv]
// Purpose: Self-checking bench for aqd_top
// Assumes: 250 MHz clock; pod model on the far side
// Notes: Inputs move by NBA at the rising edge
`timescale 1ns/100ps
module aqd_top_tb
  import aqd_pkg::*;
;
  logic clk, pod_glitch, ext_clk, clk_qual, glitch_en, recording, last_glitch;
  logic rst_n = 1'h0;
  logic int_tick = 1'h0;
  logic trig_hit = 1'h0;
  logic ext_run = 1'h0;
  logic qual_lvl = 1'h1; // Wrong level: must not matter on internal clock
  logic ext_q = 1'h0;
  logic [31:0] word = 32'hA5; // Bit 0 set so glitches show
  logic [31:0] pod_data, s_axi_rdata;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [3:0] s_axi_wstrb = 4'hF; // Full words only
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] last_addr;
  logic [1:0] last_bresp;
  logic [31:0] last_data;
  aqd_mem_s mem_wr;
  int failures = 0;
  int n_tests = 0;
  int n_wr = 0; // Stores seen
  int n_ext = 0; // Target clock rises seen
  aqd_top i_dut (.*);
  aqd_pod_model i_pod (.*);
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ==========================================
  // Monitor: NBA so tasks read stable counts
  always @(posedge clk) begin
    ext_q <= ext_clk;
    if (ext_clk && !ext_q) n_ext <= n_ext + 1;
    if (mem_wr.we) begin
      n_wr <= n_wr + 1;
      last_addr <= mem_wr.addr;
      last_glitch <= mem_wr.glitch;
      last_data <= mem_wr.data;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Bus tasks: ready sampled at negedge, acted on at the edge
  // Waits have no limit of their own: only the watchdog ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      done = s_axi_bvalid;
      if (done) last_bresp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (done) s_axi_bready <= 1'h0;
    end
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ta, done;
    done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (done) s_axi_rready <= 1'h0;
    end
    @(posedge clk);
  endtask : axi_rd
  // Internal recording clocks, spaced past the pod synchronisers
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      int_tick <= 1'h1;
      @(posedge clk);
      int_tick <= 1'h0;
    end
    repeat (4) @(posedge clk);
  endtask : tick
  task automatic capture(input logic [31:0] c, input logic [31:0] dly, input int pre,
                         input int post, output int got);
    int base;
    axi_wr(AQD_DELAY_OFS, dly);
    axi_wr(AQD_CTRL_OFS, c | 32'h1);
    base = n_wr;
    chk("armed", recording, 1'h1);
    tick(pre);
    trig_hit <= 1'h1;
    @(posedge clk);
    trig_hit <= 1'h0;
    tick(post);
    got = n_wr - base;
  endtask : capture
  // ==========================================
  // Scenarios
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(AQD_CTRL_OFS, d, r);
    chk("ctrl reset", d, AQD_CTRL_RST);
    axi_rd(8'h40, d, r);
    chk("unmapped resp", r, 2'h3);
    axi_wr(AQD_DELAY_OFS, 32'hFFFF);
    chk("write okay", last_bresp, 2'h0);
    axi_rd(AQD_DELAY_OFS, d, r);
    chk("delay clamp", d, 32'hC350);
    axi_wr(8'h40, 32'h0);
    chk("unmapped write", last_bresp, 2'h3);
    // Main cursor 10 after trigger, reference at 3
    axi_wr(AQD_CURSOR_OFS, 32'h0003_000A);
    axi_rd(AQD_MEAS_OFS, d, r);
    chk("trig to main", d, 32'hA);
    axi_wr(AQD_CTRL_OFS, 32'h200);
    axi_rd(AQD_MEAS_OFS, d, r);
    chk("ref to main", d, 32'h7);
  endtask : test_regs
  // Delay 0..3 across all widths; extra clocks past the delay
  task automatic test_delay;
    int got;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      capture(32'h100 | 32'(i << 2), 32'(i), 2, i + 2, got);
      chk("stores", got, 32'(2 + i));
      chk("stopped", recording, 1'h0);
      chk("glitch cmd", glitch_en, i == 0);
      chk("glitch kept", last_glitch, i == 0);
      chk("last addr", last_addr, 13'(1 + i));
      chk("last data", last_data, word);
      axi_rd(AQD_STATUS_OFS, d, r);
      chk("done phase", d[3:0], 4'h8);
      // Intervals since trigger equal the clocks spent delaying
      axi_rd(AQD_TICKS_OFS, d, r);
      chk("intervals", d, 32'(i));
    end
  endtask : test_delay
  task automatic test_qual;
    logic [31:0] cw [5] = '{32'h30, 32'h3C, 32'h7C, 32'h3C, 32'h7C};
    logic [31:0] qw [5] = '{32'h5A, 32'h5A, 32'h5A, 32'hA5, 32'hA5};
    int ex [5] = '{3, 0, 3, 3, 0};
    int got;
    axi_wr(AQD_QMASK_OFS, 32'hFF);
    for (int i = 0; i < 5; i++) begin
      axi_wr(AQD_QWORD_OFS, qw[i]);
      capture(cw[i], 32'h64, 3, 0, got);
      chk("qualified", got, ex[i]);
      axi_wr(AQD_CTRL_OFS, cw[i] | 32'h2);
    end
  endtask : test_qual
  // Match words open and close the gate
  task automatic test_state;
    logic [31:0] seq [5] = '{32'h0, 32'hA5, 32'h0, 32'hA5, 32'h0};
    int base;
    axi_wr(AQD_QWORD_OFS, 32'hA5);
    axi_wr(AQD_CTRL_OFS, 32'h1D);
    base = n_wr;
    foreach (seq[i]) begin
      word <= seq[i];
      tick(1);
    end
    chk("state blocks", n_wr - base, 32'h2);
    axi_wr(AQD_CTRL_OFS, 32'h1E);
  endtask : test_state
  // Target clock, qualifier wrong then right
  task automatic test_ext;
    int base, eb;
    for (int q = 0; q < 2; q++) begin
      qual_lvl <= q[0];
      axi_wr(AQD_CTRL_OFS, 32'h481);
      base = n_wr;
      eb = n_ext;
      ext_run <= 1'h1;
      repeat (40) @(posedge clk);
      ext_run <= 1'h0;
      repeat (10) @(posedge clk);
      chk("ext ran", n_ext - eb > 0, 1'h1);
      chk("ext stores", n_wr - base, q ? n_ext - eb : 0);
      axi_wr(AQD_CTRL_OFS, 32'h482);
    end
  endtask : test_ext
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    test_regs();
    test_delay();
    test_qual();
    test_state();
    test_ext();
    report_and_stop();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule : aqd_top_tb
